// ### src/jta_cfg.svh
// Constants for the test access port front end
`ifndef JTA_CFG_SVH
`define JTA_CFG_SVH

`define JTA_IR_W        4
`define JTA_IR_CAPT     4'h1
`define JTA_IR_EXTEST   4'h0
`define JTA_IR_IDCODE   4'h1
`define JTA_IR_SAMPLE   4'h2
`define JTA_IR_PROG_CTL 4'h4
`define JTA_IR_PROG_DAT 4'h5
`define JTA_IR_DBG_SCAN 4'h8
`define JTA_IR_DBG_BRK  4'h9
`define JTA_IR_BYPASS   4'hf

`define JTA_DR_MAX      32
`define JTA_LEN_W       6
`define JTA_ID_LEN      6'h20
`define JTA_BSC_LEN     6'h08
`define JTA_PROG_LEN    6'h10
`define JTA_DBG_LEN     6'h08
`define JTA_BYP_LEN     6'h01
`define JTA_BSC_W       8
`define JTA_PROG_W      16
`define JTA_DBG_W       8
// Identification value is arbitrary and names no maker or part
`define JTA_ID_VALUE    32'h0a5a5001

`define JTA_TMS_RESET_CNT 3'h5
`define JTA_FIFO_DEPTH  4

`endif

// ### src/jta_pkg.sv
// Types shared by the test access port front end
package jta_pkg;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
    } jta_state_type;

    typedef enum logic [2:0] {
        DR_BYPASS, DR_ID, DR_BSC, DR_PROG_CTL, DR_PROG_DAT, DR_DBG_SCAN, DR_DBG_BRK
    } jta_dr_sel_type;

endpackage

// ### src/jta_tap_access_enable.sv
// Test access port controller with pin enable, data registers and programming FIFO
`timescale 1ns/100ps
`include "jta_cfg.svh"

module jta_fifo
    import jta_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
)
(
    input  wire logic             clk,       // System clock
    input  wire logic             rst,       // Async reset, active high
    input  wire logic             in_valid,  // Write request
    output logic                  in_ready,  // Room for a word
    input  wire logic [WIDTH-1:0] in_data,   // Write word
    output logic                  out_valid, // Word available
    input  wire logic             out_ready, // Reader takes the word
    output logic [WIDTH-1:0]      out_data   // Oldest word
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      cnt_reg;
    logic [AW:0]      cnt_next;
    logic             push;
    logic             pop;

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = mem[rd_ptr_reg];

    always_comb
    begin
        cnt_next = cnt_reg;
        if (push && !pop)
            cnt_next = cnt_reg + (AW+1)'(1);
        else if (pop && !push)
            cnt_next = cnt_reg - (AW+1)'(1);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_reg   <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end
        else
        begin
            cnt_reg   <= cnt_next;
            in_ready  <= (cnt_next != (AW+1)'(DEPTH));
            out_valid <= (cnt_next != '0);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data;
    end
endmodule

module jta_tap_access_enable
    import jta_pkg::*;
(
    input  wire logic                  clk,                        // 250 MHz system clock
    input  wire logic                  rst,                        // Internal reset, async
    input  wire logic                  tck_pin,                    // Test clock pin
    input  wire logic                  tms_pin,                    // Mode select pin
    input  wire logic                  tdi_pin,                    // Serial data in pin
    output logic                       tdo_pin_out,                // Serial data out level
    output logic                       tdo_pin_oe,                 // Serial out driven
    input  wire logic                  test_port_enable_fuse,      // 1 = fuse programmed
    input  wire logic                  test_port_software_disable, // 1 = software disable
    input  wire logic                  debug_unlock,               // Debug chains allowed
    output logic                       port_pullup_en,             // Pull-ups on the 4 pins
    output logic                       port_pins_gpio,             // Pins are ordinary I/O
    input  wire logic [`JTA_BSC_W-1:0] bsc_pin_sample,             // Pin levels to capture
    output logic [`JTA_BSC_W-1:0]      bsc_drive,                  // Boundary drive values
    output logic                       bsc_extest,                 // Boundary cells own pins
    output logic [`JTA_PROG_W-1:0]     prog_ctl,                   // Programming control
    output logic                       prog_valid,                 // Programming word ready
    input  wire logic                  prog_ready,                 // Programmer takes word
    output logic [`JTA_PROG_W-1:0]     prog_data,                  // Programming word
    input  wire logic [`JTA_DBG_W-1:0] dbg_scan_capture,           // Internal scan input
    input  wire logic [`JTA_DBG_W-1:0] dbg_brk_capture,            // Breakpoint chain input
    output logic [`JTA_DBG_W-1:0]      dbg_scan_update,            // Internal scan output
    output logic [`JTA_DBG_W-1:0]      dbg_brk_update              // Breakpoint chain output
);
    // Synchronisers; tck, tms and tdi share depth so they stay aligned
    logic tck_s1_reg, tck_s2_reg, tck_s3_reg;
    logic tms_s1_reg, tms_s2_reg;
    logic tdi_s1_reg, tdi_s2_reg;
    logic fuse_s1_reg, fuse_s2_reg;
    logic dis_s1_reg, dis_s2_reg;
    logic unl_s1_reg, unl_s2_reg;

    jta_state_type        state_reg;
    jta_dr_sel_type       dr_sel;
    logic [`JTA_IR_W-1:0] ir_reg;
    logic [`JTA_IR_W-1:0] ir_sh_reg;
    logic [`JTA_DR_MAX-1:0] dr_sh_reg;
    logic [`JTA_DR_MAX-1:0] dr_shift_val;
    logic [`JTA_DR_MAX-1:0] dr_capt_val;
    logic [`JTA_LEN_W-1:0]  dr_len;
    logic                 tck_rise;
    logic                 tck_fall;
    logic                 port_en;
    logic                 pend_reg;
    logic [`JTA_PROG_W-1:0] pend_word_reg;
    logic                 fifo_in_ready;
    logic [2:0]           ones_cnt_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tck_s1_reg  <= 1'b0;
            tck_s2_reg  <= 1'b0;
            tck_s3_reg  <= 1'b0;
            tms_s1_reg  <= 1'b1;
            tms_s2_reg  <= 1'b1;
            tdi_s1_reg  <= 1'b1;
            tdi_s2_reg  <= 1'b1;
            fuse_s1_reg <= 1'b1;
            fuse_s2_reg <= 1'b1;
            dis_s1_reg  <= 1'b0;
            dis_s2_reg  <= 1'b0;
            unl_s1_reg  <= 1'b0;
            unl_s2_reg  <= 1'b0;
        end
        else
        begin
            tck_s1_reg  <= tck_pin;
            tck_s2_reg  <= tck_s1_reg;
            tck_s3_reg  <= tck_s2_reg;
            tms_s1_reg  <= tms_pin;
            tms_s2_reg  <= tms_s1_reg;
            tdi_s1_reg  <= tdi_pin;
            tdi_s2_reg  <= tdi_s1_reg;
            fuse_s1_reg <= test_port_enable_fuse;
            fuse_s2_reg <= fuse_s1_reg;
            dis_s1_reg  <= test_port_software_disable;
            dis_s2_reg  <= dis_s1_reg;
            unl_s1_reg  <= debug_unlock;
            unl_s2_reg  <= unl_s1_reg;
        end
    end

    // Test clock edges advance the TAP state and shift registers; clk samples them and also runs the FIFO handshake
    assign tck_rise = tck_s2_reg && !tck_s3_reg;
    assign tck_fall = !tck_s2_reg && tck_s3_reg;
    assign port_en  = fuse_s2_reg && !dis_s2_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            port_pullup_en <= 1'b0;
            port_pins_gpio <= 1'b1;
        end
        else
        begin
            port_pullup_en <= port_en;
            port_pins_gpio <= !port_en;
        end
    end

    function automatic jta_state_type next_state(input jta_state_type s, input logic tms);
        case (s)
            ST_RESET:  next_state = tms ? ST_RESET  : ST_IDLE;
            ST_IDLE:   next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  next_state = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:  next_state = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: next_state = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tms ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  next_state = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:  next_state = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: next_state = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_state = tms ? ST_SEL_IR : ST_IDLE;
            default:   next_state = ST_RESET;
        endcase
    endfunction

    // No reset pin: internal reset or five high mode bits return to reset state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state_reg <= ST_RESET;
        else if (!port_en)
            state_reg <= ST_RESET;
        else if (tck_rise)
            state_reg <= next_state(state_reg, tms_s2_reg);
    end

    // Instruction decode; debug chains fall back to bypass unless unlocked
    always_comb
    begin
        case (ir_reg)
            `JTA_IR_EXTEST:   dr_sel = DR_BSC;
            `JTA_IR_SAMPLE:   dr_sel = DR_BSC;
            `JTA_IR_IDCODE:   dr_sel = DR_ID;
            `JTA_IR_PROG_CTL: dr_sel = DR_PROG_CTL;
            `JTA_IR_PROG_DAT: dr_sel = DR_PROG_DAT;
            `JTA_IR_DBG_SCAN: dr_sel = unl_s2_reg ? DR_DBG_SCAN : DR_BYPASS;
            `JTA_IR_DBG_BRK:  dr_sel = unl_s2_reg ? DR_DBG_BRK : DR_BYPASS;
            default:          dr_sel = DR_BYPASS;
        endcase
    end

    always_comb
    begin
        dr_capt_val = '0;
        case (dr_sel)
            DR_ID:
            begin
                dr_len      = `JTA_ID_LEN;
                dr_capt_val = `JTA_ID_VALUE;
            end
            DR_BSC:
            begin
                dr_len                        = `JTA_BSC_LEN;
                dr_capt_val[`JTA_BSC_W-1:0]   = bsc_pin_sample;
            end
            DR_PROG_CTL:
            begin
                dr_len                        = `JTA_PROG_LEN;
                dr_capt_val[`JTA_PROG_W-1:0]  = prog_ctl;
            end
            DR_PROG_DAT:
            begin
                // Bit 0 reads back busy so the tester can poll before the next word
                dr_len         = `JTA_PROG_LEN;
                dr_capt_val[0] = pend_reg;
            end
            DR_DBG_SCAN:
            begin
                dr_len                        = `JTA_DBG_LEN;
                dr_capt_val[`JTA_DBG_W-1:0]   = dbg_scan_capture;
            end
            DR_DBG_BRK:
            begin
                dr_len                        = `JTA_DBG_LEN;
                dr_capt_val[`JTA_DBG_W-1:0]   = dbg_brk_capture;
            end
            default:
                dr_len = `JTA_BYP_LEN;
        endcase
    end

    // Serial in enters at the top of the selected length, bit 0 leaves first
    for (genvar i = 0; i < `JTA_DR_MAX; i++)
    begin : g_dr_shift
        if (i == `JTA_DR_MAX - 1)
        begin : g_top
            assign dr_shift_val[i] = (`JTA_LEN_W'(i) == dr_len - `JTA_LEN_W'(1)) && tdi_s2_reg;
        end
        else
        begin : g_mid
            assign dr_shift_val[i] = (`JTA_LEN_W'(i) == dr_len - `JTA_LEN_W'(1)) ? tdi_s2_reg :
                                     (`JTA_LEN_W'(i) <  dr_len - `JTA_LEN_W'(1)) ?
                                     dr_sh_reg[i+1] : 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ir_reg    <= `JTA_IR_IDCODE;
            ir_sh_reg <= `JTA_IR_CAPT;
        end
        else if (!port_en)
            ir_reg    <= `JTA_IR_IDCODE;
        else if (tck_rise)
        begin
            case (state_reg)
                ST_RESET:  ir_reg    <= `JTA_IR_IDCODE;
                ST_CAP_IR: ir_sh_reg <= `JTA_IR_CAPT;
                ST_SH_IR:  ir_sh_reg <= {tdi_s2_reg, ir_sh_reg[`JTA_IR_W-1:1]};
                ST_UPD_IR: ir_reg    <= ir_sh_reg;
                default:   ir_reg    <= ir_reg;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            dr_sh_reg <= '0;
        else if (port_en && tck_rise)
        begin
            if (state_reg == ST_CAP_DR)
                dr_sh_reg <= dr_capt_val;
            else if (state_reg == ST_SH_DR)
                dr_sh_reg <= dr_shift_val;
        end
    end

    // Update-DR effects of the selected register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bsc_drive       <= '0;
            bsc_extest      <= 1'b0;
            prog_ctl        <= '0;
            dbg_scan_update <= '0;
            dbg_brk_update  <= '0;
        end
        else
        begin
            bsc_extest <= port_en && (ir_reg == `JTA_IR_EXTEST);
            if (port_en && tck_rise && state_reg == ST_UPD_DR)
            begin
                case (dr_sel)
                    DR_BSC:      bsc_drive       <= dr_sh_reg[`JTA_BSC_W-1:0];
                    DR_PROG_CTL: prog_ctl        <= dr_sh_reg[`JTA_PROG_W-1:0];
                    DR_DBG_SCAN: dbg_scan_update <= dr_sh_reg[`JTA_DBG_W-1:0];
                    DR_DBG_BRK:  dbg_brk_update  <= dr_sh_reg[`JTA_DBG_W-1:0];
                    default:     bsc_drive       <= bsc_drive;
                endcase
            end
        end
    end

    // Virtual data register: each update hands one word to the FIFO.
    // A word updated while one is still waiting is dropped; busy readback warns.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pend_reg      <= 1'b0;
            pend_word_reg <= '0;
        end
        else if (port_en && tck_rise && state_reg == ST_UPD_DR &&
                 dr_sel == DR_PROG_DAT && !pend_reg)
        begin
            pend_reg      <= 1'b1;
            pend_word_reg <= dr_sh_reg[`JTA_PROG_W-1:0];
        end
        else if (pend_reg && fifo_in_ready)
            pend_reg      <= 1'b0;
    end

    jta_fifo #(
        .WIDTH (`JTA_PROG_W),
        .DEPTH (`JTA_FIFO_DEPTH)
    ) u_prog_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (pend_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (pend_word_reg),
        .out_valid (prog_valid),
        .out_ready (prog_ready),
        .out_data  (prog_data)
    );

    // Launch on the falling test clock so the tester samples a settled bit
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tdo_pin_out <= 1'b1;
            tdo_pin_oe  <= 1'b0;
        end
        else if (!port_en)
            tdo_pin_oe  <= 1'b0;
        else if (tck_fall)
        begin
            case (state_reg)
                ST_SH_IR:
                begin
                    tdo_pin_out <= ir_sh_reg[0];
                    tdo_pin_oe  <= 1'b1;
                end
                ST_SH_DR:
                begin
                    tdo_pin_out <= dr_sh_reg[0];
                    tdo_pin_oe  <= 1'b1;
                end
                default:
                    tdo_pin_oe  <= 1'b0;
            endcase
        end
    end

    // Helper: consecutive high mode bits, saturating
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ones_cnt_reg <= '0;
        else if (!port_en)
            ones_cnt_reg <= '0;
        else if (tck_rise)
            ones_cnt_reg <= !tms_s2_reg ? 3'h0 :
                            (ones_cnt_reg == `JTA_TMS_RESET_CNT) ? ones_cnt_reg :
                            ones_cnt_reg + 3'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_tms_reset;
        ones_cnt_reg == `JTA_TMS_RESET_CNT |-> state_reg == ST_RESET;
    endproperty
    a_tms_reset: assert property (p_tms_reset)
        else $error("five high mode bits did not reach reset state");

    property p_fuse_hold;
        !port_en |=> state_reg == ST_RESET && !tdo_pin_oe && port_pins_gpio;
    endproperty
    a_fuse_hold: assert property (p_fuse_hold)
        else $error("disabled port left reset or drove serial out");

    property p_pins_mode;
        port_en |=> port_pullup_en && !port_pins_gpio;
    endproperty
    a_pins_mode: assert property (p_pins_mode)
        else $error("pin mode does not follow port enable");

    property p_ir_capture;
        port_en && tck_rise && state_reg == ST_CAP_IR |=> ir_sh_reg == `JTA_IR_CAPT;
    endproperty
    a_ir_capture: assert property (p_ir_capture)
        else $error("instruction capture value wrong");

    property p_ir_lsb_first;
        port_en && tck_rise && state_reg == ST_SH_IR
            |=> ir_sh_reg[`JTA_IR_W-1] == $past(tdi_s2_reg) &&
                ir_sh_reg[0] == $past(ir_sh_reg[1]);
    endproperty
    a_ir_lsb_first: assert property (p_ir_lsb_first)
        else $error("instruction shift direction wrong");

    property p_ir_update;
        port_en && tck_rise && state_reg == ST_UPD_IR |=> ir_reg == $past(ir_sh_reg);
    endproperty
    a_ir_update: assert property (p_ir_update)
        else $error("instruction not latched on update");

    property p_tdo_edge;
        $changed(tdo_pin_out) |-> $past(tck_fall);
    endproperty
    a_tdo_edge: assert property (p_tdo_edge)
        else $error("serial out changed away from falling test clock");

    property p_tdo_bit;
        port_en && tck_fall && state_reg == ST_SH_DR
            |=> tdo_pin_oe && tdo_pin_out == $past(dr_sh_reg[0]);
    endproperty
    a_tdo_bit: assert property (p_tdo_bit)
        else $error("serial out does not show data register bit 0");

    property p_tdo_release;
        port_en && tck_fall && state_reg != ST_SH_DR && state_reg != ST_SH_IR
            |=> !tdo_pin_oe;
    endproperty
    a_tdo_release: assert property (p_tdo_release)
        else $error("serial out driven outside shift states");

    property p_prog_hold;
        pend_reg && !fifo_in_ready |=> pend_reg && $stable(pend_word_reg);
    endproperty
    a_prog_hold: assert property (p_prog_hold)
        else $error("programming word lost under back-pressure");
endmodule

// ### verif/jta_tester.sv
// External tester model: drives test clock, mode select and serial in
`timescale 1ns/100ps
module jta_tester
(
    output logic      tck, // Test clock, still between frames
    output logic      tms, // Mode select
    output logic      tdi,        // Serial in
    input  wire logic tdo,        // Serial out line
    output logic      rst_pull,   // Open-collector pull on chip reset
    input  wire logic chip_rst_n  // Chip reset line as seen on the board
);
    int resets_seen = 0;

    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        rst_pull = 1'b0;
    end

    // Reset line is watched so that resets from outside are noticed
    always @(negedge chip_rst_n)
        resets_seen++;

    // Pull only, never drive high: the line is shared open collector
    task automatic pull_reset;
        #0.3;
        rst_pull = 1'b1;
        #100;
        rst_pull = 1'b0;
    endtask

    // LSB first; tms/tdi change in the low phase, tdo is taken just before each rise
    task automatic scan(input int n, input logic [63:0] tmsv, input logic [63:0] tdiv,
                        output logic [63:0] tdov);
        // Start off the system clock edges so no pin change races its sampling
        #0.3;
        tdov = '0;
        for (int i = 0; i < n; i++)
        begin
            tms = tmsv[i];
            tdi = tdiv[i];
            #62.5;
            tdov[i] = tdo;
            tck = 1'b1;
            #62.5;
            tck = 1'b0;
        end
        // Released line shows no stale value
        tdi = ~tdi;
    endtask
endmodule

// ### verif/testbench.sv
// Self-checking bench for the test access port front end
`timescale 1ns/100ps
`include "jta_cfg.svh"
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        fuse = 1'b1;
    logic        sw_dis = 1'b0;
    logic        prog_ready = 1'b0;
    logic [7:0]  pins = 8'ha6;
    logic        unlock = 1'b0;
    logic        bsc_extest;
    logic [7:0]  bsc_drive, dbg_upd;
    logic [15:0] prog_ctl;
    wire         rst_pull;
    wire         chip_rst_n = !(rst || rst_pull);
    wire         tck, tms, tdi;
    logic        tdo_pin_out, tdo_pin_oe, port_pullup_en, port_pins_gpio, prog_valid;
    logic        oe_seen = 1'b0;
    logic [15:0] prog_data;
    logic [63:0] got;
    int          mismatches = 0, n_tests = 0, cycles = 0;
    wire         tdo_line = tdo_pin_oe ? tdo_pin_out : (port_pullup_en ? 1'b1 : ~tdo_pin_out);

    jta_tester u_tester (.tck, .tms, .tdi, .tdo(tdo_line), .rst_pull, .chip_rst_n);
    jta_tap_access_enable u_dut (.clk, .rst(!chip_rst_n), .tck_pin(tck), .tms_pin(tms),
        .tdi_pin(tdi), .tdo_pin_out, .tdo_pin_oe, .test_port_enable_fuse(fuse),
        .test_port_software_disable(sw_dis), .debug_unlock(unlock), .port_pullup_en,
        .port_pins_gpio, .bsc_pin_sample(pins), .bsc_drive, .bsc_extest, .prog_ctl,
        .prog_valid, .prog_ready, .prog_data, .dbg_scan_capture(8'h5c),
        .dbg_brk_capture(8'h0), .dbg_scan_update(dbg_upd), .dbg_brk_update());

    always #2 clk = ~clk;

    always @(posedge clk)
    begin
        if (tdo_pin_oe)
            oe_seen = 1'b1;
        cycles++;
        if (cycles == 30000)
        begin
            mismatches++;
            complete_run();
        end
    end

    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] seen);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // From idle: load an instruction, compare the captured value shifted out
    task automatic ir(input logic [3:0] code);
        u_tester.scan(10, 64'h183, {56'h0, code, 4'h0}, got);
        check("ir capture", 4'h1, got[7:4]);
    endtask

    task automatic dr(input int n, input logic [63:0] din, input logic [63:0] exp);
        u_tester.scan(n + 5, 64'h1 | (64'h3 << (n + 2)), din << 3, got);
        check("dr shift", exp, (got >> 3) & ((64'h1 << n) - 1));
    endtask

    task automatic t_id;
        u_tester.scan(6, 64'h1f, 64'h0, got);
        ir(4'h1);
        dr(32, 64'h0, `JTA_ID_VALUE);
    endtask

    task automatic t_bypass;
        ir(4'hf);
        dr(8, 64'hc5, 64'h8a);
    endtask

    task automatic t_sample;
        ir(4'h2);
        dr(8, 64'h0, pins);
    endtask

    // Debugger pulls the shared reset line; port must come back holding IDCODE
    task automatic t_reset;
        int seen;
        seen = u_tester.resets_seen;
        @(posedge clk);
        u_tester.pull_reset();
        repeat (6) @(posedge clk);
        check("reset seen", seen + 1, u_tester.resets_seen);
        check("pullup", 1, port_pullup_en);
        u_tester.scan(1, 64'h0, 64'h0, got);
        dr(32, 64'h0, `JTA_ID_VALUE);
    endtask

    task automatic t_extest;
        ir(4'h0);
        check("extest", 1, bsc_extest);
        dr(8, 64'h5a, pins);
        check("boundary drive", 8'h5a, bsc_drive);
        ir(4'h4);
        dr(16, 64'h1234, 64'h0);
        check("prog ctl", 16'h1234, prog_ctl);
    endtask

    // Debug chain acts as bypass while locked, as its own register once unlocked
    task automatic t_debug;
        ir(4'h8);
        dr(8, 64'h3c, 64'h78);
        @(posedge clk);
        unlock <= 1'b1;
        repeat (4) @(posedge clk);
        dr(8, 64'h96, 64'h5c);
        check("debug update", 8'h96, dbg_upd);
    endtask

    // Five words fill FIFO and pending slot; sixth reads busy and is dropped
    task automatic t_prog;
        logic [79:0] words;
        words = 80'h7e18_a5c3_8000_0001_3c1f;
        ir(4'h5);
        for (int i = 0; i < 5; i++)
            dr(16, words[16*i +: 16], 64'h0);
        dr(16, 64'hffff, 64'h1);
        repeat (4) @(posedge clk);
        for (int i = 0; i < 5; i++)
        begin
            check("prog valid", 1, prog_valid);
            check("prog word", words[16*i +: 16], prog_data);
            prog_ready <= 1'b1;
            @(posedge clk);
            prog_ready <= 1'b0;
            repeat (3) @(posedge clk);
        end
        check("prog drained", 0, prog_valid);
    endtask

    // Port switched off mid-run must drop to plain pins and come back in reset
    task automatic t_off(input logic f, input logic d);
        @(posedge clk);
        fuse <= f;
        sw_dis <= d;
        repeat (8) @(posedge clk);
        check("gpio", 1, port_pins_gpio);
        check("pullup", 0, port_pullup_en);
        oe_seen = 1'b0;
        u_tester.scan(10, 64'h183, 64'hf0, got);
        check("oe while off", 0, oe_seen);
        @(posedge clk);
        fuse <= 1'b1;
        sw_dis <= 1'b0;
        repeat (8) @(posedge clk);
        u_tester.scan(1, 64'h0, 64'h0, got);
        dr(32, 64'h0, `JTA_ID_VALUE);
    endtask

    task automatic complete_run;
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check("pullup", 1, port_pullup_en);
        check("gpio", 0, port_pins_gpio);
        t_id();
        t_bypass();
        t_sample();
        t_reset();
        t_extest();
        t_debug();
        t_prog();
        t_off(1'b1, 1'b1);
        t_off(1'b0, 1'b0);
        complete_run();
    end
endmodule
